// ===== verilog/flash_prog_consts.svh
`ifndef FLASH_PROG_CONSTS_SVH
`define FLASH_PROG_CONSTS_SVH
// ==========================================
// link command set
`define OPC_PROGRAM 8'h02
`define OPC_DUAL_PROGRAM 8'ha2
`define ERASED_BYTE 8'hff
`define OPC_LAST_CLOCK 6'd7
`define OPC_CLOCKS 6'd8
`define HDR_LAST_CLOCK 6'd31
`define HDR_CLOCKS 8'd32
`define PAGE_BYTES 9'd256
`define SERIAL_LAST_BIT 3'd7
`define DUAL_LAST_BIT 3'd6
`define SERIAL_BYTE_CLOCKS 8'd8
`define DUAL_BYTE_CLOCKS 8'd4
// ==========================================
// timing
`define CLK_PERIOD_NS 50
`define PAGE_PROGRAM_TIME_NS 100000
`define BYTE_PROGRAM_TIME_NS 20000
`define PAGE_PROGRAM_CYCLES ((`PAGE_PROGRAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BYTE_PROGRAM_CYCLES ((`BYTE_PROGRAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF_DEFAULT 4
// ==========================================
// array geometry
`define MEM_AW_DEFAULT 10
`define NUM_SECTORS_DEFAULT 64
`define SECTOR_LSB 16
// ==========================================
// controller registers
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_LEN 8'h08
`define REG_TXDATA 8'h0c
`define REG_STATUS 8'h10
`define CTRL_START_BIT 0
`define CTRL_DUAL_BIT 1
`define CTRL_OPC_LSB 8
`define CTRL_TAIL_LSB 16
`define CTRL_RESET 32'h00000000
`define ADDR_RESET 24'h000000
`define LEN_RESET 10'h000
`define TXDATA_RESET 8'h00
`endif

// ===== verilog/flash_prog_pkg.sv
package flash_prog_pkg;
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_HDR = 3'b001,
		D_DATA = 3'b011,
		D_PROG = 3'b010,
		D_SKIP = 3'b110
	} dev_state_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_HDR = 3'b001,
		H_WAIT = 3'b011,
		H_DATA = 3'b010,
		H_TAIL = 3'b110,
		H_END = 3'b111
	} host_state_t;
endpackage

// ===== verilog/flash_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic sdp_host_o;
	logic sdp_host_oe_n;
	logic sdp_dev_o;
	logic sdp_dev_oe_n;
	wire shared_data_pin;
	// weak pull-up when nobody drives
	assign shared_data_pin = !sdp_host_oe_n ? sdp_host_o : (!sdp_dev_oe_n ? sdp_dev_o : 1'b1);
	modport host(output cs_n, sck, si, sdp_host_o, sdp_host_oe_n, input shared_data_pin);
	modport device(input cs_n, sck, si, shared_data_pin, output sdp_dev_o, sdp_dev_oe_n);
endinterface
`default_nettype wire

// ===== verilog/flash_prog_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_consts.svh"
// Summary of operation
// R01: program takes one to 256 bytes, erased cells
// R02: erased byte holds all ones
// R03: host sets write enable latch first
// R04: opcode, three address bytes, then buffered data
// R05: data past page end wraps within page
// R06: only last page of bytes kept
// R07: chip select release programs buffered bytes
// R08: unsent page locations stay erased
// R09: self-timed, shorter time for single byte
// R10: abort unless address, data, byte-aligned release
// R11: protected sector start address means no program
// R12: every abort clears write enable latch; a release before all eight opcode clocks leaves it set
// R13: busy shown while programming
// R14: host polls busy instead of worst-case wait
// R15: latch cleared before program cycle ends
// R16: verify bytes, flag error on mismatch
// R17: dual opcode then address, data two bits
// R18: dual high bit on shared pin, MSB first
// R19: dual byte assembled every four clocks
// R20: opcode and address serial, MSB first
// R21: command ignored while latch is clear
module flash_prog_device import flash_prog_pkg::*; #(
	parameter int MEM_AW = `MEM_AW_DEFAULT,
	parameter int NUM_SECTORS = `NUM_SECTORS_DEFAULT,
	parameter int PP_CYCLES = `PAGE_PROGRAM_CYCLES,
	parameter int BP_CYCLES = `BYTE_PROGRAM_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	flash_link_if.device link,
	input wire logic wel_set_i,
	input wire logic [NUM_SECTORS-1:0] sector_protect_i,
	input wire logic [NUM_SECTORS-1:0] sector_lockdown_i,
	input wire logic [MEM_AW-1:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	output logic busy_o,
	output logic write_enable_latch_o,
	output logic program_erase_error_flag_o
);
	localparam int SB = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;
	localparam int MEM_DEPTH = 1 << MEM_AW;
	localparam logic [15:0] PP_CYC = 16'(PP_CYCLES);
	localparam logic [15:0] BP_CYC = 16'(BP_CYCLES);

	function automatic logic [MEM_AW-1:0] mem_index(input logic [23:0] a, input logic [7:0] ix);
		logic [23:0] full;
		full = {a[23:8], ix};
		return full[MEM_AW-1:0];
	endfunction

	// ==========================================
	// pin synchronisers: {cs_n, sck, si, shared}
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic cs_prev_q;
	logic sck_prev_q;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// idle levels: deselected, clock low, data low, shared pin pulled high
			s1_q <= 4'h9;
			s2_q <= 4'h9;
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			s1_q <= {link.cs_n, link.sck, link.si, link.shared_data_pin};
			s2_q <= s1_q;
			cs_prev_q <= s2_q[3];
			sck_prev_q <= s2_q[2];
		end
	end
	wire cs_n_s = s2_q[3];
	wire si_s = s2_q[1];
	wire sdp_s = s2_q[0];
	wire sck_rise = s2_q[2] & ~sck_prev_q & ~cs_n_s;
	wire cs_fall = ~cs_n_s & cs_prev_q;
	wire cs_rise = cs_n_s & ~cs_prev_q;

	// this end only ever receives in these commands
	assign link.sdp_dev_o = 1'b0;
	assign link.sdp_dev_oe_n = 1'b1;

	// ==========================================
	// frame state
	dev_state_t state_q;
	logic [5:0] clk_cnt_q;
	logic [31:0] sh_q;
	logic dual_q;
	logic [7:0] byte_q;
	logic [2:0] bit_cnt_q;
	logic [8:0] nbytes_q;
	logic [7:0] wr_idx_q;
	logic [7:0] buf_q [256];
	logic [255:0] vld_q;
	logic [7:0] mem_q [MEM_DEPTH];
	logic [8:0] walk_q;
	logic [15:0] timer_q;
	logic wel_q;
	logic epe_q;
	logic [7:0] rd_data_q;

	wire [7:0] opc_now = {sh_q[6:0], si_s};
	wire opc_known = (opc_now == `OPC_PROGRAM) || (opc_now == `OPC_DUAL_PROGRAM);
	wire opc_ok = opc_known & wel_q; // R03 R21
	wire [23:0] start_addr = sh_q[23:0];
	wire [SB-1:0] sector = start_addr[`SECTOR_LSB +: SB];
	wire locked = sector_protect_i[sector] | sector_lockdown_i[sector];
	// R18: shared pin carries the higher bit of each pair
	wire [7:0] byte_now = dual_q ? {byte_q[5:0], sdp_s, si_s} : {byte_q[6:0], si_s};
	wire [2:0] last_bit = dual_q ? `DUAL_LAST_BIT : `SERIAL_LAST_BIT;
	wire byte_done = sck_rise && (state_q == D_DATA) && (bit_cnt_q == last_bit); // R19
	wire frame_ok = (nbytes_q != 9'd0) && (bit_cnt_q == 3'd0) && !locked; // R10 R11
	wire walk_end = walk_q[8];
	wire walk_wr = (state_q == D_PROG) && !walk_end && vld_q[walk_q[7:0]]; // R08
	wire [MEM_AW-1:0] wr_ix = mem_index(start_addr, walk_q[7:0]); // R05 R07
	// cells only go from one to zero, so a non-erased target cannot take the data
	wire [7:0] merged = mem_q[wr_ix] & buf_q[walk_q[7:0]]; // R01
	wire verify_bad = walk_wr && (merged != buf_q[walk_q[7:0]]); // R16
	wire abort_hdr = cs_rise && (state_q == D_HDR) && (clk_cnt_q >= `OPC_CLOCKS);
	wire abort_data = cs_rise && (state_q == D_DATA) && !frame_ok;
	wire wel_clr = abort_hdr | abort_data | ((state_q == D_PROG) && walk_end); // R12 R15
	wire prog_done = (state_q == D_PROG) && walk_end && (timer_q == 16'd0);

	// ==========================================
	// command sequencer
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= D_IDLE;
			clk_cnt_q <= 6'd0;
			sh_q <= 32'h00000000;
			dual_q <= 1'b0;
			byte_q <= 8'h00;
			bit_cnt_q <= 3'd0;
			nbytes_q <= 9'd0;
			wr_idx_q <= 8'h00;
			walk_q <= 9'd0;
			timer_q <= 16'd0;
		end else begin
			case (state_q)
				D_IDLE: begin
					if (cs_fall) begin
						state_q <= D_HDR;
						clk_cnt_q <= 6'd0;
						bit_cnt_q <= 3'd0;
						nbytes_q <= 9'd0;
					end
				end
				D_HDR: begin
					if (cs_rise) begin
						state_q <= D_IDLE; // R10
					end else if (sck_rise) begin
						sh_q <= {sh_q[30:0], si_s}; // R20
						clk_cnt_q <= clk_cnt_q + 6'd1;
						if (clk_cnt_q == `OPC_LAST_CLOCK) begin
							dual_q <= (opc_now == `OPC_DUAL_PROGRAM); // R17
							if (!opc_ok) begin
								state_q <= D_SKIP; // R21
							end
						end else if (clk_cnt_q == `HDR_LAST_CLOCK) begin
							state_q <= D_DATA; // R04
							wr_idx_q <= {sh_q[6:0], si_s};
						end
					end
				end
				D_DATA: begin
					if (cs_rise) begin
						state_q <= frame_ok ? D_PROG : D_IDLE; // R07 R10 R11
						walk_q <= 9'd0;
						timer_q <= (nbytes_q == 9'd1) ? BP_CYC : PP_CYC; // R09
					end else if (sck_rise) begin
						byte_q <= byte_now;
						bit_cnt_q <= byte_done ? 3'd0 : (bit_cnt_q + (dual_q ? 3'd2 : 3'd1));
						if (byte_done) begin
							wr_idx_q <= wr_idx_q + 8'd1; // R05
							if (nbytes_q != `PAGE_BYTES) begin
								nbytes_q <= nbytes_q + 9'd1;
							end
						end
					end
				end
				D_PROG: begin
					if (!walk_end) begin
						walk_q <= walk_q + 9'd1;
					end
					if (timer_q != 16'd0) begin
						timer_q <= timer_q - 16'd1;
					end
					if (prog_done) begin
						state_q <= D_IDLE;
					end
				end
				D_SKIP: begin
					if (cs_rise) begin
						state_q <= D_IDLE;
					end
				end
				default: begin
					state_q <= D_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// page buffer: index wraps, so later bytes overwrite earlier ones
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vld_q <= '0;
			for (int i = 0; i < 256; i++) begin
				buf_q[i] <= `ERASED_BYTE;
			end
		end else if (cs_fall && (state_q == D_IDLE)) begin
			vld_q <= '0;
		end else if (byte_done) begin
			buf_q[wr_idx_q] <= byte_now; // R06
			vld_q[wr_idx_q] <= 1'b1;
		end
	end

	// ==========================================
	// array: walks all 256 page slots, one per cycle
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_q[i] <= `ERASED_BYTE; // R02
			end
			rd_data_q <= `ERASED_BYTE;
		end else begin
			if (walk_wr) begin
				mem_q[wr_ix] <= merged; // R07
			end
			rd_data_q <= mem_q[rd_addr_i];
		end
	end

	// ==========================================
	// status bits; an outside set of the latch wins over a clear
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wel_q <= 1'b0;
			epe_q <= 1'b0;
		end else begin
			wel_q <= wel_set_i | (wel_q & ~wel_clr); // R12 R15
			if (cs_rise && (state_q == D_DATA) && frame_ok) begin
				epe_q <= 1'b0;
			end else if (verify_bad) begin
				epe_q <= 1'b1; // R16
			end
		end
	end

	assign busy_o = (state_q == D_PROG); // R13
	assign write_enable_latch_o = wel_q;
	assign program_erase_error_flag_o = epe_q;
	assign rd_data_o = rd_data_q;
endmodule
`default_nettype wire

// ===== verilog/flash_prog_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_consts.svh"
module flash_prog_host import flash_prog_pkg::*; #(
	parameter int SCK_HALF = `SCK_HALF_DEFAULT
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	flash_link_if.host link,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	localparam logic [7:0] HALF = 8'(SCK_HALF);
	localparam logic [7:0] SLOT_LAST = 8'(2 * SCK_HALF - 1);

	// ==========================================
	// registers
	host_state_t state_q;
	logic dual_q;
	logic [7:0] opc_q;
	logic [2:0] tail_q;
	logic [23:0] addr_q;
	logic [9:0] len_q;
	logic [7:0] txdata_q;
	logic txv_q;
	logic [31:0] prdata_q;

	wire acc = psel_i & penable_i;
	wire wr = acc & pwrite_i;
	wire wr_ctrl = wr && (paddr_i == `REG_CTRL);
	wire wr_tx = wr && (paddr_i == `REG_TXDATA);
	wire start = wr_ctrl && pwdata_i[`CTRL_START_BIT] && (state_q == H_IDLE);
	wire load = (state_q == H_WAIT) && txv_q;
	wire busy = (state_q != H_IDLE);
	wire [31:0] rd_word = (paddr_i == `REG_CTRL) ? {13'h0000, tail_q, opc_q, 6'h00, dual_q, 1'b0} :
		(paddr_i == `REG_ADDR) ? {8'h00, addr_q} :
		(paddr_i == `REG_LEN) ? {22'h000000, len_q} :
		(paddr_i == `REG_TXDATA) ? {24'h000000, txdata_q} :
		(paddr_i == `REG_STATUS) ? {30'h00000000, txv_q, busy} : 32'h00000000;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dual_q <= 1'b0;
			opc_q <= `OPC_PROGRAM;
			tail_q <= 3'd0;
			addr_q <= `ADDR_RESET;
			len_q <= `LEN_RESET;
			txdata_q <= `TXDATA_RESET;
			txv_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			if (wr_ctrl && !busy) begin
				dual_q <= pwdata_i[`CTRL_DUAL_BIT];
				opc_q <= pwdata_i[`CTRL_OPC_LSB +: 8];
				tail_q <= pwdata_i[`CTRL_TAIL_LSB +: 3];
			end
			if (wr && (paddr_i == `REG_ADDR) && !busy) begin
				addr_q <= pwdata_i[23:0];
			end
			if (wr && (paddr_i == `REG_LEN) && !busy) begin
				len_q <= pwdata_i[9:0];
			end
			if (wr_tx) begin
				txdata_q <= pwdata_i[7:0];
			end
			// a fresh write wins over the load that empties the holding register
			txv_q <= wr_tx | (txv_q & ~load);
			if (psel_i && !penable_i) begin
				prdata_q <= rd_word;
			end
		end
	end
	assign prdata_o = prdata_q;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;

	// ==========================================
	// link sequencer: each bit slot is low half then high half of sck
	logic [7:0] slot_q;
	logic [7:0] bits_q;
	logic [9:0] left_q;
	logic [31:0] hdr_q;
	logic [7:0] byte_q;
	logic cs_n_q;
	logic sck_q;
	logic si_q;
	logic sdp_q;
	logic sdp_oe_n_q;

	wire shifting = (state_q == H_HDR) || (state_q == H_DATA) || (state_q == H_TAIL);
	wire slot_end = shifting && (slot_q == SLOT_LAST);
	wire last_bit = (bits_q == 8'd1);
	wire [7:0] byte_bits = dual_q ? `DUAL_BYTE_CLOCKS : `SERIAL_BYTE_CLOCKS;
	wire more_tail = (tail_q != 3'd0);
	// let go of the shared pin at the last clock so it never outlasts chip select
	wire dual_out = (state_q == H_DATA) && dual_q && !(slot_end && last_bit); // R17
	wire si_bit = (state_q == H_HDR) ? hdr_q[31] : (state_q == H_DATA) ? (dual_q ? byte_q[6] : byte_q[7]) : 1'b0;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= H_IDLE;
			slot_q <= 8'd0;
			bits_q <= 8'd0;
			left_q <= 10'd0;
			hdr_q <= 32'h00000000;
			byte_q <= 8'h00;
			cs_n_q <= 1'b1;
		end else begin
			slot_q <= (shifting && !slot_end) ? (slot_q + 8'd1) : 8'd0;
			case (state_q)
				H_IDLE: begin
					if (start) begin
						state_q <= H_HDR;
						// the opcode comes from the same write that starts the frame
						hdr_q <= {pwdata_i[`CTRL_OPC_LSB +: 8], addr_q}; // R04 R17
						bits_q <= `HDR_CLOCKS;
						left_q <= len_q;
						cs_n_q <= 1'b0;
					end
				end
				H_HDR: begin
					if (slot_end) begin
						hdr_q <= {hdr_q[30:0], 1'b0}; // R20
						bits_q <= bits_q - 8'd1;
						if (last_bit) begin
							state_q <= (left_q != 10'd0) ? H_WAIT : (more_tail ? H_TAIL : H_END);
							bits_q <= (left_q != 10'd0) ? 8'd0 : (more_tail ? {5'h00, tail_q} : 8'(2 * SCK_HALF));
							cs_n_q <= (left_q != 10'd0) || more_tail ? 1'b0 : 1'b1;
						end
					end
				end
				H_WAIT: begin
					if (load) begin
						state_q <= H_DATA;
						byte_q <= txdata_q;
						bits_q <= byte_bits;
					end
				end
				H_DATA: begin
					if (slot_end) begin
						byte_q <= dual_q ? {byte_q[5:0], 2'b00} : {byte_q[6:0], 1'b0};
						bits_q <= bits_q - 8'd1;
						if (last_bit) begin
							left_q <= left_q - 10'd1;
							state_q <= (left_q != 10'd1) ? H_WAIT : (more_tail ? H_TAIL : H_END);
							bits_q <= more_tail ? {5'h00, tail_q} : 8'(2 * SCK_HALF);
							cs_n_q <= (left_q != 10'd1) || more_tail ? 1'b0 : 1'b1;
						end
					end
				end
				H_TAIL: begin
					if (slot_end) begin
						bits_q <= last_bit ? 8'(2 * SCK_HALF) : (bits_q - 8'd1);
						if (last_bit) begin
							state_q <= H_END;
							cs_n_q <= 1'b1;
						end
					end
				end
				H_END: begin
					// hold chip select high long enough for the far end to see it
					bits_q <= bits_q - 8'd1;
					if (bits_q == 8'd0) begin
						state_q <= H_IDLE;
					end
				end
				default: begin
					state_q <= H_IDLE;
					cs_n_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sck_q <= 1'b0;
			si_q <= 1'b0;
			sdp_q <= 1'b0;
			sdp_oe_n_q <= 1'b1;
		end else begin
			sck_q <= shifting && (slot_q >= HALF - 8'd1) && !slot_end;
			si_q <= si_bit;
			sdp_q <= byte_q[7]; // R18
			sdp_oe_n_q <= ~dual_out;
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck = sck_q;
	assign link.si = si_q;
	assign link.sdp_host_o = sdp_q;
	assign link.sdp_host_oe_n = sdp_oe_n_q;
endmodule
`default_nettype wire

// ===== sim/flash_prog_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_prog_checker #(
	parameter int PP_CYCLES = 2000,
	parameter int BP_CYCLES = 400
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic sdp_host_oe_n,
	input wire logic shared_data_pin,
	input wire logic busy_o,
	input wire logic write_enable_latch_o
);
	// ==========================================
	// busy run length
	int blen_q;
	int blen_d;
	assign blen_d = busy_o ? blen_q + 1 : 0;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			blen_q <= 0;
		end else begin
			blen_q <= blen_d;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	// ==========================================
	// link framing
	a_sck_idle: assert property (cs_n |-> !sck) else $error("clock runs outside frame");
	a_sck_high: assert property ($rose(sck) |-> sck [*4]) else $error("clock high phase short");
	// both lanes must hold still while the device may sample them
	a_data_stable: assert property (sck && $past(sck) |-> $stable(si) && $stable(shared_data_pin))
		else $error("data moved while clock high");
	a_shared_frame: assert property (!sdp_host_oe_n |-> !cs_n) else $error("shared pin driven idle");
	a_cs_gap: assert property ($rose(cs_n) |=> cs_n [*8]) else $error("deselect gap short");
	// ==========================================
	// program cycle
	a_busy_release: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 2))
		else $error("busy without release");
	a_busy_wel: assert property ($rose(busy_o) |-> $past(write_enable_latch_o))
		else $error("program without latch");
	a_wel_done: assert property ($fell(busy_o) |-> !$past(write_enable_latch_o))
		else $error("latch set at program end");
	a_busy_min: assert property ($fell(busy_o) |-> blen_q >= BP_CYCLES) else $error("program too short");
	a_busy_max: assert property (busy_o |-> blen_q < PP_CYCLES + 8) else $error("program too long");
	c_program: cover property ($rose(busy_o));
	c_dual: cover property (!sdp_host_oe_n && sck);
	c_release: cover property ($rose(cs_n));
endmodule
`default_nettype wire

// ===== sim/serial_flash_page_program_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_consts.svh"
module serial_flash_page_program_bench;
	// short program times keep the run small; byte time stays above the 256-cycle walk
	localparam int PP = 600;
	localparam int BP = 300;
	typedef struct packed {
		logic dual;
		logic [7:0] opc;
		logic [23:0] addr;
		logic [9:0] len;
		logic [2:0] tail;
		logic write_enable_latch;
		logic [1:0] prot;
		logic prog;
		logic wel_o;
		logic program_erase_error_flag;
	} case_t;
	case_t rows [10] = '{
		'{1'b0, 8'h02, 24'h000000, 10'h001, 3'h0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0},
		'{1'b1, 8'ha2, 24'h0001fe, 10'h003, 3'h0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0},
		'{1'b0, 8'h02, 24'h000205, 10'h102, 3'h0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0},
		'{1'b0, 8'h02, 24'h000310, 10'h002, 3'h3, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 8'h02, 24'h000320, 10'h000, 3'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 8'h03, 24'h000330, 10'h001, 3'h0, 1'b1, 2'h0, 1'b0, 1'b1, 1'b0},
		'{1'b1, 8'ha2, 24'h010340, 10'h001, 3'h0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0},
		'{1'b0, 8'h02, 24'h020350, 10'h001, 3'h0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0},
		'{1'b0, 8'h02, 24'h000000, 10'h001, 3'h0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1},
		'{1'b1, 8'ha2, 24'h000380, 10'h002, 3'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1}
	};
	logic ref_clk, resetn, psel, penable, pwrite, wel_set, pready, pslverr, busy, write_enable_latch, program_erase_error_flag, busy_seen;
	logic [7:0] paddr, rd_data, rd_v;
	logic [31:0] pwdata, prdata, rd_w;
	logic [63:0] prot_v, lock_v;
	logic [9:0] rd_addr;
	logic [7:0] exp_mem [1024];
	int error_cnt, total_checks, cyc, busy_len;
	flash_link_if lnk();
	flash_prog_host u_flash_prog_host (.ref_clk_i(ref_clk), .resetn_i(resetn), .link(lnk), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));
	flash_prog_device #(.PP_CYCLES(PP), .BP_CYCLES(BP)) u_flash_prog_device (.ref_clk_i(ref_clk),
		.resetn_i(resetn), .link(lnk), .wel_set_i(wel_set), .sector_protect_i(prot_v), .sector_lockdown_i(lock_v),
		.rd_addr_i(rd_addr), .rd_data_o(rd_data), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
		.program_erase_error_flag_o(program_erase_error_flag));
	flash_prog_checker #(.PP_CYCLES(PP), .BP_CYCLES(BP)) u_flash_prog_checker (.ref_clk_i(ref_clk),
		.resetn_i(resetn), .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .sdp_host_oe_n(lnk.sdp_host_oe_n),
		.shared_data_pin(lnk.shared_data_pin), .busy_o(busy), .write_enable_latch_o(write_enable_latch));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ==========================================
	// watchdog and busy monitor
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			error_cnt++;
			finish_test;
		end
	end
	// sampled on the falling edge so busy has settled
	always @(negedge ref_clk) begin
		if (lnk.cs_n === 1'b0) begin
			busy_len <= 0;
			busy_seen <= 1'b0;
		end else if (busy === 1'b1) begin
			busy_len <= busy_len + 1;
			busy_seen <= 1'b1;
		end
	end
	// ==========================================
	// tasks
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task finish_test;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task poll(input int b);
		logic [31:0] r;
		do apb(1'b0, `REG_STATUS, 32'h0, r); while (r[b] !== 1'b0);
	endtask
	task rdarr(input logic [9:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rd_addr <= a;
		repeat (2) @(posedge ref_clk);
		d = rd_data;
	endtask
	task run(input case_t c, input int k);
		logic [31:0] r;
		logic [9:0] pg;
		int t;
		if (c.write_enable_latch) begin
			@(posedge ref_clk);
			wel_set <= 1'b1;
			@(posedge ref_clk);
			wel_set <= 1'b0;
		end
		prot_v <= c.prot[0] ? 64'h1 << c.addr[21:16] : 64'h0;
		lock_v <= c.prot[1] ? 64'h1 << c.addr[21:16] : 64'h0;
		apb(1'b1, `REG_ADDR, {8'h00, c.addr}, r);
		apb(1'b1, `REG_LEN, {22'h0, c.len}, r);
		apb(1'b1, `REG_CTRL, {13'h0, c.tail, c.opc, 6'h0, c.dual, 1'b1}, r);
		for (int i = 0; i < c.len; i++) begin
			poll(1);
			apb(1'b1, `REG_TXDATA, {24'h0, 8'(k * 16 + i * 7 + 3)}, r);
		end
		poll(0);
		repeat (20) @(posedge ref_clk);
		check("busy seen", 32'(busy_seen), 32'(c.prog));
		while (busy === 1'b1) @(posedge ref_clk);
		@(posedge ref_clk);
		t = (c.len == 1) ? BP : PP;
		if (c.prog) check("busy time", 32'(busy_len >= t && busy_len <= t + 3), 32'h1);
		check("wel", 32'(write_enable_latch), 32'(c.wel_o));
		check("epe", 32'(program_erase_error_flag), 32'(c.program_erase_error_flag));
		if (c.prog) begin
			// only the last page-sized run lands, each byte can only clear bits
			for (int i = (c.len > 256) ? c.len - 256 : 0; i < c.len; i++) begin
				exp_mem[{c.addr[9:8], 8'(c.addr[7:0] + i)}] &= 8'(k * 16 + i * 7 + 3);
			end
		end
		pg = {c.addr[9:8], 8'h00};
		for (int j = 0; j < 256; j++) begin
			rdarr(pg + 10'(j), rd_v);
			check("array", 32'(rd_v), 32'(exp_mem[pg + 10'(j)]));
		end
		prot_v <= 64'h0;
		lock_v <= 64'h0;
	endtask
	// ==========================================
	// main sequence
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wel_set = 1'b0;
		prot_v = 64'h0;
		lock_v = 64'h0;
		rd_addr = 10'h000;
		foreach (exp_mem[i]) exp_mem[i] = 8'hff;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[k]) run(rows[k], k);
		// second reset with the latch set and a programmed byte in the array
		@(posedge ref_clk);
		wel_set <= 1'b1;
		@(posedge ref_clk);
		wel_set <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		check("wel reset", 32'(write_enable_latch), 32'h0);
		check("epe reset", 32'(program_erase_error_flag), 32'h0);
		check("busy reset", 32'(busy), 32'h0);
		rdarr(10'h000, rd_v);
		check("erased", 32'(rd_v), 32'hff);
		apb(1'b0, `REG_CTRL, 32'h0, rd_w);
		check("ctrl reset", rd_w, 32'h00000200);
		check("slave error", 32'(pslverr), 32'h0);
		finish_test;
	end
endmodule
`default_nettype wire
